// ==== verilog/nfs_rpc_header_parser.sv ====
// receive-side nfs/rpc header walker that places the header split point
// assumes metadata arrives before the first payload byte
//
// Behaviour
// - search payload only when the destination port is 0x801
// - destination port 0x801 means write request
// - source port 0x801 with any other destination port means read response
// - size checks use low two bytes only
// - six per-type enables gate nfs splitting
// - nfs length added to transport header length
// - tcp adds four-byte record marker first
// - message type zero, rpc version two
// - program word must equal nfs program
// - version two with procedure eight
// - version three with procedure seven
// - credential and verifier sizes below limit
// - credentials padded to four bytes
// - verifier padded to four, after flavor word
// - version two length 80 plus extras
// - version three file handle size below limit
// - file handle padded to four bytes
// - version three length 56 plus extras
`timescale 1ns/100ps
module nfs_rpc_header_parser
  import nfs_split_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // frame metadata from the transport parser
  input  wire logic                meta_valid,
  input  wire rx_meta_t            meta,
  // transport payload, one byte a beat
  input  wire logic                pay_valid,
  input  wire rx_byte_t            pay,
  // split position towards the receive dma
  output logic                     res_valid,
  output split_result_t            res,
  // register bus
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_RMARK = 5'b00010,
    S_WORD  = 5'b00100,
    S_SKIP  = 5'b01000,
    S_DRAIN = 5'b10000
  } state_t;

  state_t        state;
  state_t        next_state;
  field_t        field;
  field_t        next_field;
  logic [15:0]   remaining;
  logic [15:0]   next_remaining;
  logic [1:0]    byte_cnt;
  logic [23:0]   shift;
  logic          is_v3;
  logic [15:0]   base_len;
  logic [15:0]   rm_len;
  logic [15:0]   cred_pad;
  logic [15:0]   verf_pad;
  logic [5:0]    split_enable;
  logic [31:0]   word;
  logic          word_ok;
  logic          word_v3;
  logic          word_done;
  logic          type_enabled;
  logic          is_write;
  logic          is_read;
  logic          fin;
  logic          fin_ok;
  logic [15:0]   fin_fh_pad;
  logic          start_parse;
  logic          start_bypass;
  logic [15:0]   write_count;
  logic [15:0]   reject_count;

  assign word      = {shift, pay.data};
  assign word_done = (state == S_WORD) && pay_valid && (byte_cnt == 2'h3);

  // ----------------------------------------
  // frame classification
  // ----------------------------------------
  assign is_write     = (meta.dst_port == NFS_SERVICE_PORT);
  assign is_read      = (meta.src_port == NFS_SERVICE_PORT) && !is_write;
  assign type_enabled = (meta.ptype < 3'(NFS_TYPE_COUNT)) && split_enable[meta.ptype];
  // read responses are not walked, only writes
  assign start_parse  = meta_valid && (state == S_IDLE || state == S_DRAIN)
                        && is_write && type_enabled;
  assign start_bypass = meta_valid && (state == S_IDLE || state == S_DRAIN) && !start_parse;

  nfs_word_check u_check (
    .field   (field),
    .word    (word),
    .is_v3   (is_v3),
    .ok      (word_ok),
    .v3_word (word_v3)
  );

  // ----------------------------------------
  // walk of the header fields
  // ----------------------------------------
  always_comb begin
    next_state     = state;
    next_field     = field;
    next_remaining = remaining;
    fin            = 1'b0;
    fin_ok         = 1'b0;
    fin_fh_pad     = 16'h0000;
    case (state)
      S_IDLE: begin
        if (start_parse) begin
          next_field     = F_MSG;
          next_remaining = RECORD_MARK_TCP;
          // rpc starts at the payload for udp, after the four-byte record marker for tcp
          next_state     = meta.is_tcp ? S_RMARK : S_WORD;
        end else if (start_bypass) begin
          next_state = S_DRAIN;
        end
      end
      S_RMARK: begin
        if (pay_valid) begin
          if (pay.last) begin
            fin        = 1'b1;
            next_state = S_IDLE;
          end else if (remaining == 16'h0001) begin
            next_state = S_WORD;
          end else begin
            next_remaining = remaining - 16'h0001;
          end
        end
      end
      S_WORD: begin
        if (word_done) begin
          if (!word_ok) begin
            fin        = 1'b1;
            next_state = pay.last ? S_IDLE : S_DRAIN;
          end else begin
            case (field)
              F_CRED: begin
                next_field     = F_VFLAV;
                next_remaining = pad4(word[15:0]);
                next_state     = (pad4(word[15:0]) == 16'h0000) ? S_WORD : S_SKIP;
              end
              F_VSIZE: begin
                next_field     = is_v3 ? F_FHSIZE : F_DONE;
                next_remaining = pad4(word[15:0]);
                if (pad4(word[15:0]) != 16'h0000) begin
                  next_state = S_SKIP;
                end else if (!is_v3) begin
                  fin        = 1'b1;
                  fin_ok     = 1'b1;
                  next_state = pay.last ? S_IDLE : S_DRAIN;
                end
              end
              F_FHSIZE: begin
                fin        = 1'b1;
                fin_ok     = 1'b1;
                fin_fh_pad = pad4(word[15:0]);
                next_state = pay.last ? S_IDLE : S_DRAIN;
              end
              default: begin
                next_field = field_t'(field + 4'h1);
              end
            endcase
            if (pay.last && !fin) begin
              fin        = 1'b1;
              fin_ok     = 1'b0;
              next_state = S_IDLE;
            end
          end
        end else if (pay_valid && pay.last) begin
          fin        = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_SKIP: begin
        if (pay_valid) begin
          if (remaining == 16'h0001 && field == F_DONE) begin
            fin        = 1'b1;
            fin_ok     = 1'b1;
            next_state = pay.last ? S_IDLE : S_DRAIN;
          end else if (pay.last) begin
            fin        = 1'b1;
            next_state = S_IDLE;
          end else if (remaining == 16'h0001) begin
            next_state = S_WORD;
          end else begin
            next_remaining = remaining - 16'h0001;
          end
        end
      end
      S_DRAIN: begin
        if (start_parse) begin
          next_field     = F_MSG;
          next_remaining = RECORD_MARK_TCP;
          next_state     = meta.is_tcp ? S_RMARK : S_WORD;
        end else if (pay_valid && pay.last && !meta_valid) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= S_IDLE;
      field     <= F_MSG;
      remaining <= 16'h0000;
    end else begin
      state     <= next_state;
      field     <= next_field;
      remaining <= next_remaining;
    end
  end

  // ----------------------------------------
  // word assembly and per-frame context
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_cnt <= 2'h0;
      shift    <= 24'h000000;
    end else if (state != S_WORD || next_state != S_WORD && !word_done) begin
      byte_cnt <= 2'h0;
    end else if (pay_valid) begin
      byte_cnt <= byte_cnt + 2'h1;
      shift    <= {shift[15:0], pay.data};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      is_v3    <= 1'b0;
      base_len <= 16'h0000;
      rm_len   <= 16'h0000;
      cred_pad <= 16'h0000;
      verf_pad <= 16'h0000;
    end else if (start_parse || start_bypass) begin
      is_v3    <= 1'b0;
      base_len <= meta.base_len;
      rm_len   <= meta.is_tcp ? RECORD_MARK_TCP : 16'h0000;
      cred_pad <= 16'h0000;
      verf_pad <= 16'h0000;
    end else if (word_done && word_ok) begin
      if (field == F_PROGVER) begin
        is_v3 <= word_v3;
      end
      if (field == F_CRED) begin
        cred_pad <= pad4(word[15:0]);
      end
      if (field == F_VSIZE) begin
        verf_pad <= pad4(word[15:0]);
      end
    end
  end

  // ----------------------------------------
  // split result
  // ----------------------------------------
  // verifier size may land in the finishing beat
  logic [15:0] verf_now;
  logic [15:0] nfs_len_now;

  always_comb begin
    verf_now    = (state == S_WORD && field == F_VSIZE) ? pad4(word[15:0]) : verf_pad;
    nfs_len_now = is_v3 ? V3_FIXED_LEN + rm_len + cred_pad + verf_now + fin_fh_pad
                        : V2_FIXED_LEN + rm_len + cred_pad + verf_now;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_valid <= 1'b0;
      res       <= '0;
    end else begin
      res_valid <= 1'b0;
      if (start_bypass) begin
        res_valid     <= 1'b1;
        res.split_len <= meta.base_len;
        res.nfs_len   <= 16'h0000;
        res.nfs_found <= 1'b0;
        res.read_resp <= is_read;
        res.nfs_v3    <= 1'b0;
      end else if (fin) begin
        res_valid     <= 1'b1;
        res.read_resp <= 1'b0;
        if (fin_ok) begin
          res.split_len <= base_len + nfs_len_now;
          res.nfs_len   <= nfs_len_now;
          res.nfs_found <= 1'b1;
          res.nfs_v3    <= is_v3;
        end else begin
          res.split_len <= base_len;
          res.nfs_len   <= 16'h0000;
          res.nfs_found <= 1'b0;
          res.nfs_v3    <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // statistics for software
  // ----------------------------------------
  // counters wrap; software samples them as a pair in one read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_count  <= 16'h0000;
      reject_count <= 16'h0000;
    end else if (fin) begin
      if (fin_ok) begin
        write_count <= write_count + 16'h0001;
      end else begin
        reject_count <= reject_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  split_cfg_axil #(
    .ADDR_W (ADDR_W)
  ) u_cfg (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .awaddr       (awaddr),
    .awvalid      (awvalid),
    .awready      (awready),
    .wdata        (wdata),
    .wstrb        (wstrb),
    .wvalid       (wvalid),
    .wready       (wready),
    .bresp        (bresp),
    .bvalid       (bvalid),
    .bready       (bready),
    .araddr       (araddr),
    .arvalid      (arvalid),
    .arready      (arready),
    .rdata        (rdata),
    .rresp        (rresp),
    .rvalid       (rvalid),
    .rready       (rready),
    .split_enable (split_enable),
    .last_result  (res),
    .write_count  (write_count),
    .reject_count (reject_count)
  );

endmodule

// ==== verilog/nfs_split_pkg.sv ====
// constants, carriers and helpers of the nfs/rpc header split parser
// assumes a single receive clock domain shared by all users
package nfs_split_pkg;

  // ----------------------------------------
  // protocol constants
  // ----------------------------------------
  localparam logic [15:0] NFS_SERVICE_PORT = 16'h0801;
  localparam logic [31:0] MSG_TYPE_CALL    = 32'h00000000;
  localparam logic [31:0] RPC_VERSION_TWO  = 32'h00000002;
  localparam logic [31:0] NFS_PROGRAM      = 32'h00018a63;
  localparam logic [31:0] PROG_VER_TWO     = 32'h00000002;
  localparam logic [31:0] PROG_VER_THREE   = 32'h00000003;
  localparam logic [31:0] PROC_WRITE_V2    = 32'h00000008;
  localparam logic [31:0] PROC_WRITE_V3    = 32'h00000007;
  localparam logic [15:0] AUTH_SIZE_LIMIT  = 16'h0400;
  localparam logic [15:0] FHANDLE_LIMIT    = 16'h0064;
  localparam logic [15:0] RECORD_MARK_TCP  = 16'h0004;
  localparam logic [15:0] V2_FIXED_LEN     = 16'h0050;
  localparam logic [15:0] V3_FIXED_LEN     = 16'h0038;
  localparam int          NFS_TYPE_COUNT   = 6;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_SPLIT_CFG   = 8'h00;
  localparam logic [7:0] REG_LAST_RESULT = 8'h04;
  localparam logic [7:0] REG_COUNTERS    = 8'h08;
  localparam int NFS_SPLIT_ENABLE_A_BIT  = 0;
  localparam int NFS_SPLIT_ENABLE_F_BIT  = 5;
  localparam logic [5:0] SPLIT_CFG_RESET = 6'h00;
  localparam int LAST_FOUND_BIT          = 16;
  localparam int LAST_READ_RESP_BIT      = 17;
  localparam int LAST_V3_BIT             = 18;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    F_MSG = 4'h0, F_RPCVER = 4'h1, F_PROG = 4'h2, F_PROGVER = 4'h3, F_PROC = 4'h4,
    F_CRED = 4'h5, F_VFLAV = 4'h6, F_VSIZE = 4'h7, F_FHSIZE = 4'h8, F_DONE = 4'h9
  } field_t;

  typedef struct packed {
    logic [2:0]  ptype;
    logic        is_tcp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [15:0] base_len;
  } rx_meta_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rx_byte_t;

  typedef struct packed {
    logic [15:0] split_len;
    logic [15:0] nfs_len;
    logic        nfs_found;
    logic        read_resp;
    logic        nfs_v3;
  } split_result_t;

  function automatic logic [15:0] pad4(input logic [15:0] v);
    logic [16:0] s;
    s = {1'b0, v} + 17'h00003;
    pad4 = {s[15:2], 2'b00};
  endfunction

endpackage

// ==== verilog/nfs_word_check.sv ====
// compares one completed rpc/nfs header word against its expected value
// assumes field names the word just assembled
`timescale 1ns/100ps
module nfs_word_check
  import nfs_split_pkg::*;
(
  input  wire field_t      field,
  input  wire logic [31:0] word,
  input  wire logic        is_v3,
  output logic             ok,
  output logic             v3_word
);

  always_comb begin
    v3_word = (word == PROG_VER_THREE);
    case (field)
      F_MSG:     ok = (word == MSG_TYPE_CALL);
      F_RPCVER:  ok = (word == RPC_VERSION_TWO);
      F_PROG:    ok = (word == NFS_PROGRAM);
      F_PROGVER: ok = (word == PROG_VER_TWO) || (word == PROG_VER_THREE);
      F_PROC:    ok = is_v3 ? (word == PROC_WRITE_V3) : (word == PROC_WRITE_V2);
      // size words: upper halves ignored
      F_CRED:    ok = (word[15:0] < AUTH_SIZE_LIMIT);
      F_VFLAV:   ok = 1'b1;
      F_VSIZE:   ok = (word[15:0] < AUTH_SIZE_LIMIT);
      F_FHSIZE:  ok = (word[15:0] < FHANDLE_LIMIT);
      default:   ok = 1'b0;
    endcase
  end

endmodule

// ==== verilog/split_cfg_axil.sv ====
// axi4-lite slave holding the split enables and showing parser status
// assumes one write and one read outstanding at most, 32-bit data
`timescale 1ns/100ps
module split_cfg_axil
  import nfs_split_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [5:0]               split_enable,
  input  wire split_result_t       last_result,
  input  wire logic [15:0]         write_count,
  input  wire logic [15:0]         reject_count
);

  if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie in 4..8");
  end

  logic              aw_got;
  logic              w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [7:0]        wr_addr;
  logic [7:0]        rd_addr;

  assign wr_addr = 8'(aw_addr);
  assign rd_addr = 8'(araddr);

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      awready      <= 1'b0;
      wready       <= 1'b0;
      bvalid       <= 1'b0;
      bresp        <= RESP_OKAY;
      split_enable <= SPLIT_CFG_RESET;
    end else begin
      awready <= !aw_got && !(awvalid && awready) && !bvalid;
      wready  <= !w_got && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (aw_got && w_got && !bvalid) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= RESP_OKAY;
        if (wr_addr == REG_SPLIT_CFG) begin
          if (w_strb[0]) begin
            split_enable <= w_data[NFS_SPLIT_ENABLE_F_BIT:NFS_SPLIT_ENABLE_A_BIT];
          end
        end else if (wr_addr != REG_LAST_RESULT && wr_addr != REG_COUNTERS) begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        rdata  <= 32'h00000000;
        case (rd_addr)
          REG_SPLIT_CFG:   rdata <= {26'h0000000, split_enable};
          REG_LAST_RESULT: rdata <= {13'h0000, last_result.nfs_v3, last_result.read_resp,
                                     last_result.nfs_found, last_result.nfs_len};
          REG_COUNTERS:    rdata <= {reject_count, write_count};
          default:         rresp <= RESP_SLVERR;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== verification/nfs_split_monitor.sv ====
// port assertions for the nfs split parser
// assumes one clock domain, reset synchronous active low
`timescale 1ns/100ps
module nfs_split_monitor
  import nfs_split_pkg::*;
(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          meta_valid,
  input wire rx_meta_t      meta,
  input wire logic          res_valid,
  input wire split_result_t res,
  input wire logic          rvalid,
  input wire logic          rready,
  input wire logic [31:0]   rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] base_q;
  logic [15:0] dst_q;
  logic [15:0] mark_q;
  wire         src_hit = meta.src_port == NFS_SERVICE_PORT;
  wire         dst_hit = meta.dst_port == NFS_SERVICE_PORT;
  // context of the last announced frame
  always_ff @(posedge aclk) begin
    if (meta_valid) begin
      base_q <= meta.base_len;
      dst_q <= meta.dst_port;
      mark_q <= meta.is_tcp ? RECORD_MARK_TCP : 16'h0000;
    end
  end
  plain_bypass_a: assert property (meta_valid && !src_hit && !dst_hit |=> res_valid && !res.nfs_found)
    else $error("bypass result missing");
  read_resp_a: assert property (meta_valid && src_hit && !dst_hit |=> res_valid && res.read_resp)
    else $error("read response not flagged");
  split_sum_a: assert property (res_valid |-> res.split_len == base_q + res.nfs_len)
    else $error("split is not base plus nfs length");
  no_header_a: assert property (res_valid && !res.nfs_found |-> res.nfs_len == 16'h0000)
    else $error("nfs length on failed frame");
  write_dir_a: assert property (res_valid && res.nfs_found |-> dst_q == NFS_SERVICE_PORT && !res.read_resp)
    else $error("write found off service port");
  v2_len_a: assert property (res_valid && res.nfs_found && !res.nfs_v3 |->
    res.nfs_len >= V2_FIXED_LEN + mark_q && res.nfs_len[1:0] == 2'h0)
    else $error("v2 header length off");
  v3_len_a: assert property (res_valid && res.nfs_found && res.nfs_v3 |->
    res.nfs_len >= V3_FIXED_LEN + mark_q && res.nfs_len[1:0] == 2'h0)
    else $error("v3 header length off");
  res_pulse_a: assert property (res_valid |=> !res_valid)
    else $error("result not one pulse");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  cover property (res_valid && res.nfs_found && res.nfs_v3);
  cover property (res_valid && res.nfs_found && !res.nfs_v3);
  cover property (res_valid && res.read_resp);
endmodule

// ==== verification/frame_source.sv ====
// upstream transport parser model: metadata pulse, then payload bytes
// assumes one send at a time
`timescale 1ns/100ps
module frame_source
  import nfs_split_pkg::*;
(
  input  wire logic aclk,
  output logic      meta_valid,
  output rx_meta_t  meta,
  output logic      pay_valid,
  output rx_byte_t  pay
);
  initial begin
    meta_valid = 1'b0;
    meta = '0;
    pay_valid = 1'b0;
    pay = '0;
  end
  task automatic send(input rx_meta_t m, input logic [7:0] q[$], input int gap);
    repeat (gap) @(posedge aclk);
    meta_valid <= 1'b1;
    meta <= m;
    @(posedge aclk);
    meta_valid <= 1'b0;
    meta <= ~m;
    // rpc begins at the first payload byte, or after the four-byte record marker for tcp
    foreach (q[i]) begin
      pay_valid <= 1'b1;
      pay <= '{data: q[i], last: i == q.size() - 1};
      @(posedge aclk);
    end
    // idle byte lines show junk
    pay_valid <= 1'b0;
    pay <= '{data: ~pay.data, last: 1'b0};
    @(posedge aclk);
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the nfs split parser
// assumes the package and parser under verilog/
`timescale 1ns/100ps
module tb;
  import nfs_split_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic          meta_valid, pay_valid, res_valid, awready, wready, bvalid, arready, rvalid;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h0, rdata, seed = 32'h0fd1342c;
  logic [1:0]    bresp, rresp;
  logic [5:0]    cfg = 6'h00;
  rx_meta_t      meta;
  rx_byte_t      pay;
  split_result_t res, last_e, exp_q[$];
  logic [33:0]   rd_q[$];
  logic [7:0]    fq[$];
  int            err_total = 0, n_checks = 0;
  always #10 aclk = ~aclk;
  nfs_rpc_header_parser dut (.*, .wstrb(4'hf));
  frame_source src (.*);
  function automatic logic [31:0] xr();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] p4(input logic [15:0] v);
    return 16'((int'(v) + 3) / 4 * 4);
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic flag(input logic [35:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // v3 is don't-care on rejects
  task automatic cmp_res(input split_result_t e, g);
    if (!e.nfs_found)
      g.nfs_v3 = e.nfs_v3;
    flag(e, g);
  endtask
  task automatic cmp_rd(input logic [33:0] e, g);
    flag({2'h0, e}, {2'h0, g});
  endtask
  always @(posedge aclk) if (res_valid === 1'b1) cmp_res(exp_q.pop_front(), res);
  always @(posedge aclk) if ((rvalid & rready) === 1'b1) cmp_rd(rd_q.pop_front(), {rresp, rdata});
  // ----------------------------------------
  // bus cycles and frames
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (bvalid !== 1'b1) @(posedge aclk);
    flag({34'h0, RESP_OKAY}, {34'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic put(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) fq.push_back(w[i*8 +: 8]);
  endtask
  task automatic fill(input logic [15:0] n);
    repeat (n) fq.push_back(xr() >> 8);
  endtask
  // kind 0 write, 1 read response, 2 other ports
  task automatic frame(input int kind, bad, input logic tcp, v3, input logic [15:0] cs, vs, fs, input logic [2:0] pt);
    rx_meta_t    m;
    logic        ok;
    logic [15:0] n;
    m = '{pt, tcp, kind == 1 ? NFS_SERVICE_PORT : 16'h0203, kind == 0 ? NFS_SERVICE_PORT : 16'h0405, 16'(xr() & 32'hff)};
    ok = kind == 0 && bad == 0 && pt < 6 && cfg[pt] && cs < AUTH_SIZE_LIMIT && vs < AUTH_SIZE_LIMIT && !(v3 && fs >= FHANDLE_LIMIT);
    fq = {};
    if (tcp) put(xr());
    put(bad == 1 ? 32'h1 : MSG_TYPE_CALL);
    put(bad == 2 ? 32'h3 : RPC_VERSION_TWO);
    put(bad == 3 ? 32'h18a62 : NFS_PROGRAM);
    put(v3 ? PROG_VER_THREE : PROG_VER_TWO);
    put(bad == 4 ? 32'h6 : v3 ? PROC_WRITE_V3 : PROC_WRITE_V2);
    put({16'(xr()), cs});
    fill(p4(cs));
    put(xr());
    put({16'(xr()), vs});
    fill(p4(vs));
    if (v3) put({16'(xr()), fs});
    if (v3) fill(p4(fs));
    fill(16'd24);
    n = (v3 ? V3_FIXED_LEN : V2_FIXED_LEN) + (tcp ? RECORD_MARK_TCP : 16'h0) + p4(cs) + p4(vs) + (v3 ? p4(fs) : 16'h0);
    last_e = '{m.base_len + (ok ? n : 16'h0), ok ? n : 16'h0, ok, kind == 1, v3};
    exp_q.push_back(last_e);
    src.send(m, fq, int'(xr() % 3));
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_SPLIT_CFG, 34'h0);
    cfg = 6'h3f;
    wr(REG_SPLIT_CFG, 32'h3f);
    rd(REG_SPLIT_CFG, 34'h3f);
    rd(8'h0c, {RESP_SLVERR, 32'h0});
    frame(0, 0, 0, 0, 16'h0, 16'h0, 16'h0, 3'h0);
    frame(0, 0, 1, 1, 16'h3ff, 16'h3, 16'h63, 3'h5);
    wait (exp_q.size() == 0);
    rd(REG_LAST_RESULT, {15'h0, last_e.nfs_v3, last_e.read_resp, last_e.nfs_found, last_e.nfs_len});
    frame(0, 0, 0, 1, 16'h0, 16'h0, 16'h64, 3'h1);
    frame(0, 0, 1, 0, 16'h400, 16'h0, 16'h0, 3'h2);
    frame(0, 0, 0, 0, 16'h1, 16'h400, 16'h0, 3'h3);
    for (int b = 1; b < 5; b++) frame(0, b, b[0], b[1], 16'h5, 16'h2, 16'h7, 3'h4);
    for (int k = 1; k < 3; k++) frame(k, 0, 1, 0, 16'h0, 16'h0, 16'h0, 3'h0);
    for (int i = 0; i < 20; i++) frame(int'(xr() % 4) / 2 * (1 + i % 2) , int'(xr() % 5), xr() >> 31, xr() >> 31,
      16'(xr() % 40), 16'(xr() % 40), 16'(xr() % 100), 3'(xr()));
    cfg = 6'h3e;
    wr(REG_SPLIT_CFG, 32'h3e);
    frame(0, 0, 1, 1, 16'h8, 16'h0, 16'h4, 3'h0);
    frame(0, 0, 1, 1, 16'h8, 16'h0, 16'h4, 3'h1);
    wait (exp_q.size() == 0);
    complete_run();
  end
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
endmodule
bind nfs_rpc_header_parser nfs_split_monitor mon (.*);
